// File: logic/dbsp_pkg.sv
// Package: widths, timing counts and carrier types of the burst-of-two SRAM port
package dbsp_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int DATA_W    = 18;                 // One burst word
    localparam int LANES     = 2;                  // Byte lanes per word
    localparam int LANE_W    = DATA_W / LANES;     // Bits per byte lane
    localparam int ADDR_W    = 8;                  // Pair address width
    localparam int PAIR_W    = 2 * DATA_W;         // Word pair as stored in the array
    localparam int BURST_LEN = 2;                  // Words per access
    localparam int FIFO_DEPTH_DEF = 32;            // Read return buffer depth

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CORE_NS      = 100;             // Core clock period
    localparam int STOP_NS      = 30;              // Least stall that resets the loop
    localparam int STOP_CYC_RAW = (STOP_NS + CORE_NS - 1) / CORE_NS;
    localparam int STOP_CYC     = (STOP_CYC_RAW < 1) ? 1 : STOP_CYC_RAW;
    localparam int LOCK_CYC     = 2048;            // Stable link cycles to lock
    localparam int CAL_CYC      = 1024;            // Link cycles between recalibrations
    localparam int GAP_W        = 8;               // Width of the link period meter

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [DATA_W-1:0] DQ_RST    = 18'h00000;
    localparam logic [GAP_W-1:0]  GAP_RST   = 8'h00;
    localparam logic [GAP_W-1:0]  GAP_MAX   = 8'hff;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic              k;                      // Positive-phase link clock
        logic              k_n;                    // Negative-phase link clock
        logic              load_strobe_n;          // Access request, active low
        logic              rw;                     // High read, low write
        logic [ADDR_W-1:0] addr;                   // Pair address
        logic [LANES-1:0]  byte_lane_mask_n;       // Lane write enables, active low
        logic [DATA_W-1:0] dq;                     // Write data from the pins
        logic              loop_disable_n;         // Low bypasses the delay loop
    } dbsp_link_in_t;

    typedef struct packed {
        logic              valid;                  // Entry occupied
        logic [ADDR_W-1:0] addr;                   // Target pair address
        logic [PAIR_W-1:0] data;                   // {second word, first word}
        logic [2*LANES-1:0] lane_we;               // Active-high lane enables
    } dbsp_post_t;

endpackage

// File: logic/dbsp_port.sv
// Burst-of-two DDR SRAM port: link sampling, array, posted write and read return buffer

// ************************************************************
// Read return buffer
// ************************************************************
module dbsp_fifo
    import dbsp_pkg::*;
#(
    parameter int WIDTH = PAIR_W,
    parameter int DEPTH = FIFO_DEPTH_DEF
) (
    input  wire logic             core_clk_i,  // Core clock
    input  wire logic             resetn_i,    // Async reset, active low
    input  wire logic             ce_i,        // Clock enable
    input  wire logic             in_valid_i,  // Push request
    output logic                  in_ready_o,  // Room available
    input  wire logic [WIDTH-1:0] in_data_i,   // Push data
    output logic                  out_valid_o, // Data available
    input  wire logic             out_ready_i, // Pop request
    output logic [WIDTH-1:0]      out_data_o   // Head data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    rd_ptr;
    logic [PW-1:0]    wr_ptr;
    logic [PW:0]      count;
    logic [PW-1:0]    next_rd_ptr;
    logic [PW-1:0]    next_wr_ptr;
    logic [PW:0]      next_count;
    logic             push;
    logic             pop;

    // Honest flags straight from the occupancy count
    assign in_ready_o  = (count < (PW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o  = mem[rd_ptr];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_ready_i && out_valid_o;

    // Pointer and count update
    always_comb begin
        next_wr_ptr = push ? PW'(wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr = pop ? PW'(rd_ptr + 1'b1) : rd_ptr;
        next_count  = count;
        if (push && !pop) begin
            next_count = (PW+1)'(count + 1'b1);
        end else if (pop && !push) begin
            next_count = (PW+1)'(count - 1'b1);
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_ptr <= '0;
            wr_ptr <= '0;
            count  <= '0;
        end else if (ce_i) begin
            rd_ptr <= next_rd_ptr;
            wr_ptr <= next_wr_ptr;
            count  <= next_count;
        end
    end

    // Storage has no reset; the head entry mem[rd_ptr] is shown on out_data_o even while the buffer is empty
    always_ff @(posedge core_clk_i) begin
        if (ce_i && push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end
endmodule

// ************************************************************
// Port top
// ************************************************************
module dbsp_port
    import dbsp_pkg::*;
#(
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
    input  wire logic          core_clk_i,          // Core clock, 10 MHz
    input  wire logic          resetn_i,            // Async reset, active low
    input  wire logic          ce_i,                // Clock enable, low freezes all
    input  wire dbsp_link_in_t link_i,              // Link pins from the controller
    output logic [DATA_W-1:0]  dq_o,                // Read data to the pins
    output logic               dq_oe_o,             // High while driving data
    output logic               output_valid_flag_o, // Read data valid soon
    output logic               echo_timing_out_o,   // Echo of positive phase
    output logic               echo_timing_out_n_o, // Echo of negative phase
    output logic               dll_locked_o,        // Delay loop locked
    output logic               imped_update_o       // One-cycle recalibration pulse
);

    typedef struct packed {
        logic               rd0;        // Read taken last link cycle
        logic               rd1;        // Read taken two link cycles ago
        logic [ADDR_W-1:0]  ra0;
        logic [ADDR_W-1:0]  ra1;
        logic               wr0;        // Write address taken, data due
        logic [ADDR_W-1:0]  wa0;
        logic               wr_hi;      // Second write word due on negative phase
        logic [ADDR_W-1:0]  asm_addr;
        logic [DATA_W-1:0]  asm_d0;
        logic [LANES-1:0]   asm_m0;
        dbsp_post_t         post;
        logic               lkp_req;
        logic [ADDR_W-1:0]  lkp_addr;
        logic [DATA_W-1:0]  hold1;
        logic               drive_hi;
        logic [DATA_W-1:0]  dq;
        logic               oe;
        logic               vld;
        logic               echo_p;
        logic               echo_n;
        logic [9:0]         cal_cnt;
        logic               cal_pulse;
        logic [11:0]        lock_cnt;
        logic               locked;
        logic [GAP_W-1:0]   gap_cnt;
        logic [GAP_W-1:0]   last_gap;
    } dbsp_state_t;

    dbsp_link_in_t      pin_s1;
    dbsp_link_in_t      pin_s2;
    dbsp_link_in_t      pin_d;
    dbsp_state_t        st;
    dbsp_state_t        next_st;
    logic [PAIR_W-1:0]  mem [2**ADDR_W];
    logic               mem_we;
    logic [ADDR_W-1:0]  mem_addr;
    logic [PAIR_W-1:0]  mem_wdata;
    logic [PAIR_W-1:0]  lkp_data;
    logic               fifo_in_ready;
    logic               fifo_out_valid;
    logic [PAIR_W-1:0]  fifo_out_data;
    logic               fifo_push;
    logic               fifo_pop;
    logic               k_rise;
    logic               kn_rise;
    logic               dll_on;
    logic               rd_due;
    logic [ADDR_W-1:0]  rd_due_addr;

    // Pins come from the controller's clock: two flops before any use
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            pin_d  <= '0;
        end else if (ce_i) begin
            pin_s1 <= link_i;
            pin_s2 <= pin_s1;
            pin_d  <= pin_s2;
        end
    end

    // Link edges found by the core clock; every pin is delayed alike
    assign k_rise  = pin_s2.k && !pin_d.k;
    assign kn_rise = pin_s2.k_n && !pin_d.k_n;
    assign dll_on  = pin_s2.loop_disable_n;
    // Bypassed loop shortens the read pipe by one link cycle
    assign rd_due      = dll_on ? st.rd1 : st.rd0;
    assign rd_due_addr = dll_on ? st.ra1 : st.ra0;

    // Array lookup, newest posted lanes win over the array copy
    always_comb begin
        lkp_data = mem[st.lkp_addr];
        for (int i = 0; i < 2*LANES; i++) begin
            if (st.post.valid && st.post.addr == st.lkp_addr && st.post.lane_we[i]) begin
                lkp_data[i*LANE_W +: LANE_W] = st.post.data[i*LANE_W +: LANE_W];
            end
        end
    end

    // Lookup waits while the return buffer is full
    assign fifo_push = st.lkp_req;
    assign fifo_pop  = k_rise && rd_due;

    // Next-state logic of the whole port
    always_comb begin
        next_st           = st;
        next_st.cal_pulse = 1'b0;
        mem_we            = 1'b0;
        mem_addr          = st.post.addr;
        mem_wdata         = mem[st.post.addr];
        if (st.lkp_req && fifo_in_ready) begin
            next_st.lkp_req = 1'b0;
        end
        next_st.echo_p = pin_s2.k;
        next_st.echo_n = pin_s2.k_n;
        if (st.gap_cnt != GAP_MAX) begin
            next_st.gap_cnt = GAP_W'(st.gap_cnt + 1'b1);
        end
        // Slowed or stopped link clock drops the lock
        if (st.last_gap != GAP_RST
            && st.gap_cnt > GAP_W'(st.last_gap + GAP_W'(STOP_CYC))) begin
            next_st.locked   = 1'b0;
            next_st.lock_cnt = '0;
        end
        if (k_rise) begin
            next_st.gap_cnt  = GAP_RST;
            next_st.last_gap = st.gap_cnt;
            if (dll_on && !st.locked) begin
                next_st.lock_cnt = 12'(st.lock_cnt + 1'b1);
                if (st.lock_cnt == 12'(LOCK_CYC - 1)) begin
                    next_st.locked = 1'b1;
                end
            end
            next_st.cal_cnt = 10'(st.cal_cnt + 1'b1);
            if (st.cal_cnt == 10'(CAL_CYC - 1)) begin
                next_st.cal_pulse = 1'b1;
            end
            // Commands only on the positive phase; a deselect takes nothing
            next_st.rd0 = !pin_s2.load_strobe_n && pin_s2.rw;
            next_st.ra0 = pin_s2.addr;
            next_st.rd1 = st.rd0;
            next_st.ra1 = st.ra0;
            next_st.wr0 = !pin_s2.load_strobe_n && !pin_s2.rw;
            next_st.wa0 = pin_s2.addr;
            // First write word and its lanes one cycle after the address
            if (st.wr0) begin
                next_st.asm_addr = st.wa0;
                next_st.asm_d0   = pin_s2.dq;
                next_st.asm_m0   = pin_s2.byte_lane_mask_n;
                next_st.wr_hi    = 1'b1;
            end
            // First read word launched, second held for the other phase
            if (rd_due) begin
                next_st.dq       = fifo_out_valid ? fifo_out_data[DATA_W-1:0] : DQ_RST;
                next_st.hold1    = fifo_out_data[PAIR_W-1:DATA_W];
                next_st.drive_hi = 1'b1;
                next_st.oe       = 1'b1;
            end
        end
        if (kn_rise) begin
            // Second write word completes the burst; older posted pair goes in now
            if (st.wr_hi) begin
                next_st.wr_hi        = 1'b0;
                next_st.post.valid   = 1'b1;
                next_st.post.addr    = st.asm_addr;
                next_st.post.data    = {pin_s2.dq, st.asm_d0};
                next_st.post.lane_we = ~{pin_s2.byte_lane_mask_n, st.asm_m0};
                if (st.post.valid) begin
                    mem_we = 1'b1;
                end
            end
            // Second read word, else float after this edge once reads stop
            if (st.drive_hi) begin
                next_st.dq       = st.hold1;
                next_st.drive_hi = 1'b0;
            end else begin
                next_st.oe = 1'b0;
            end
            // Valid leads the data by half a link cycle
            next_st.vld = rd_due;
            if (rd_due) begin
                next_st.lkp_req  = 1'b1;
                next_st.lkp_addr = rd_due_addr;
            end
        end
        // Lane merge of the committed pair; masked lanes keep the array copy
        for (int i = 0; i < 2*LANES; i++) begin
            if (st.post.lane_we[i]) begin
                mem_wdata[i*LANE_W +: LANE_W] = st.post.data[i*LANE_W +: LANE_W];
            end
        end
    end

    // Port state; comes up deselected with data lines floating
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st <= '0;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    // Array write port, both words of a pair in one write
    always_ff @(posedge core_clk_i) begin
        if (ce_i && mem_we) begin
            mem[mem_addr] <= mem_wdata;
        end
    end

    // Return buffer between lookup and launch
    dbsp_fifo #(
        .WIDTH (PAIR_W),
        .DEPTH (FIFO_DEPTH)
    ) dbsp_fifo_inst (
        .core_clk_i  (core_clk_i),
        .resetn_i    (resetn_i),
        .ce_i        (ce_i),
        .in_valid_i  (fifo_push),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (lkp_data),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (fifo_pop),
        .out_data_o  (fifo_out_data)
    );

    // All outputs from flops
    assign dq_o                = st.dq;
    assign dq_oe_o             = st.oe;
    assign output_valid_flag_o = st.vld;
    assign echo_timing_out_o   = st.echo_p;
    assign echo_timing_out_n_o = st.echo_n;
    assign dll_locked_o        = st.locked;
    assign imped_update_o      = st.cal_pulse;
endmodule

// File: verification/dbsp_port_asserts.sv
// Checker: timing relations seen at the pins of the burst-of-two SRAM port
module dbsp_port_asserts
    import dbsp_pkg::*;
(
    input wire logic              core_clk_i,          // Core clock
    input wire logic              resetn_i,            // Reset, active low
    input wire logic              ce_i,                // Clock enable
    input wire dbsp_link_in_t     link_i,              // Link pins
    input wire logic [DATA_W-1:0] dq_o,                // Read data
    input wire logic              dq_oe_o,             // Data drive
    input wire logic              output_valid_flag_o, // Valid flag
    input wire logic              echo_timing_out_o,   // Echo, k phase
    input wire logic              echo_timing_out_n_o, // Echo, k_n phase
    input wire logic              dll_locked_o,        // Loop locked
    input wire logic              imped_update_o       // Recal pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    // ************************************************************
    // Link clock history
    // ************************************************************
    logic [15:0] krise;
    logic [15:0] next_krise;
    logic [7:0]  gap;
    logic [7:0]  next_gap;
    logic        k_d;
    // Rises of raw k since reset; gap saturates so a long stall stays visible
    always_comb begin
        next_krise = krise;
        next_gap = (gap == 8'hff) ? gap : gap + 8'h01;
        if (link_i.k && !k_d) begin
            next_krise = (krise == 16'hffff) ? krise : krise + 16'h0001;
            next_gap = 8'h00;
        end
    end
    // Registers only
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            krise <= 16'h0000;
            gap <= 8'h00;
            k_d <= 1'b0;
        end else begin
            krise <= next_krise;
            gap <= next_gap;
            k_d <= link_i.k;
        end
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    // Echo may lag the pin by the sync chain plus one register
    chk_echo_pos: assert property ($past(resetn_i, 4) |-> echo_timing_out_o == $past(link_i.k, 3)
        || echo_timing_out_o == $past(link_i.k, 4)) else $error("k echo lost");
    chk_echo_neg: assert property ($past(resetn_i, 4) |-> echo_timing_out_n_o ==
        $past(link_i.k_n, 3) || echo_timing_out_n_o == $past(link_i.k_n, 4))
        else $error("k_n echo lost");
    chk_recal_pulse: assert property (imped_update_o |=> !imped_update_o)
        else $error("recal pulse too long");
    chk_valid_lead: assert property ($rose(output_valid_flag_o) |-> ##[3:5] dq_oe_o)
        else $error("valid not half a cycle ahead of data");
    chk_burst_whole: assert property ($rose(dq_oe_o) |-> dq_oe_o [*8])
        else $error("burst cut short");
    chk_float_after: assert property ($fell(output_valid_flag_o) |-> dq_oe_o [*8] ##1
        (!dq_oe_o || output_valid_flag_o)) else $error("output not released");
    chk_word_hold: assert property (dq_oe_o && $past(dq_oe_o) && $changed(dq_o) |=>
        $stable(dq_o) [*3]) else $error("word changed inside a phase");
    chk_lock_count: assert property ($rose(dll_locked_o) |-> krise >= 16'h0800)
        else $error("locked too early");
    chk_stall_unlock: assert property (gap == 8'h14 |-> !dll_locked_o)
        else $error("lock kept through stall");
endmodule

bind dbsp_port dbsp_port_asserts dbsp_port_asserts_inst (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .link_i(link_i), .dq_o(dq_o),
    .dq_oe_o(dq_oe_o), .output_valid_flag_o(output_valid_flag_o),
    .echo_timing_out_o(echo_timing_out_o), .echo_timing_out_n_o(echo_timing_out_n_o),
    .dll_locked_o(dll_locked_o), .imped_update_o(imped_update_o)
);

// File: verification/dbsp_ctrl_model.sv
// Controller model: drives the link and records the port's answers at each phase edge
module dbsp_ctrl_model
    import dbsp_pkg::*;
(
    input  wire logic              core_clk_i, // Core clock paces the link
    input  wire logic [DATA_W-1:0] dq_i,       // Read data from the port
    input  wire logic              dq_oe_i,    // Port drives data
    input  wire logic              valid_i,    // Port valid flag
    output dbsp_link_in_t          link_o      // Link pins to the port
);
    timeunit 1ns;
    timeprecision 1ns;
    int                n;
    logic [DATA_W-1:0] q_k [2400];
    logic [DATA_W-1:0] q_kn [2400];
    logic              oe_k [2400];
    logic              v_k [2400];
    // Idle link: k parked low, strobe high, loop in use
    initial begin
        n = 0;
        link_o = '0;
        link_o.k_n = 1'b1;
        link_o.load_strobe_n = 1'b1;
        link_o.loop_disable_n = 1'b1;
    end
    // One link cycle of 8 core cycles; entered at a falling core edge
    task automatic cyc(input logic ld_n, input logic rw, input logic [ADDR_W-1:0] a,
                       input logic [PAIR_W-1:0] d, input logic [2*LANES-1:0] m_n);
        link_o.load_strobe_n = ld_n;
        link_o.rw = rw;
        link_o.addr = a;
        link_o.dq = d[DATA_W-1:0];
        link_o.byte_lane_mask_n = m_n[LANES-1:0];
        repeat (2) @(negedge core_clk_i);
        q_k[n] = dq_i;
        oe_k[n] = dq_oe_i;
        v_k[n] = valid_i;
        link_o.k = 1'b1;
        link_o.k_n = 1'b0;
        repeat (2) @(negedge core_clk_i);
        // Control turns to a bogus request, which only a k_n sampler would take
        link_o.load_strobe_n = 1'b0;
        link_o.rw = ~rw;
        link_o.addr = ~a;
        link_o.dq = d[PAIR_W-1:DATA_W];
        link_o.byte_lane_mask_n = m_n[2*LANES-1:LANES];
        repeat (2) @(negedge core_clk_i);
        q_kn[n] = dq_i;
        link_o.k = 1'b0;
        link_o.k_n = 1'b1;
        repeat (2) @(negedge core_clk_i);
        n++;
    endtask
    // Clock stands for c core cycles; loop mode may change only here
    task automatic hold(input int c, input logic loop_n);
        link_o.loop_disable_n = loop_n;
        repeat (c) @(negedge core_clk_i);
    endtask
endmodule

// File: verification/tb_ddr_burst2_sram_port.sv
// Testbench: drives the SRAM port through the controller model and judges its answers
module tb_ddr_burst2_sram_port
    import dbsp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [PAIR_W-1:0] NOISE = 36'h5a5a5a5a5;
    logic              core_clk;
    logic              resetn;
    dbsp_link_in_t     link;
    logic [DATA_W-1:0] dq;
    logic              dq_oe, valid, echo_p, echo_n, locked, imped;
    int                failures = 0;
    int                checked = 0;
    int                pulses = 0;
    int                r;
    dbsp_port dbsp_port_inst (
        .core_clk_i(core_clk), .resetn_i(resetn), .ce_i(1'b1), .link_i(link), .dq_o(dq),
        .dq_oe_o(dq_oe), .output_valid_flag_o(valid), .echo_timing_out_o(echo_p),
        .echo_timing_out_n_o(echo_n), .dll_locked_o(locked), .imped_update_o(imped)
    );
    dbsp_ctrl_model dbsp_ctrl_model_inst (
        .core_clk_i(core_clk), .dq_i(dq), .dq_oe_i(dq_oe), .valid_i(valid), .link_o(link)
    );
    // 10 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // Recalibration pulses over the whole run, sampled off the launching edge
    always @(negedge core_clk) begin
        if (imped === 1'b1) pulses++;
    end
    task automatic check(input logic [PAIR_W-1:0] seen, input logic [PAIR_W-1:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    // Burst of a read started in cycle t; lag is 2 with the loop on, 1 in bypass
    function automatic logic [PAIR_W-1:0] rd(input int t, input int lag);
        return {dbsp_ctrl_model_inst.q_k[t+lag+1], dbsp_ctrl_model_inst.q_kn[t+lag]};
    endfunction
    // Nops carry write-like noise that must never land in the array
    task automatic nop(input int c);
        repeat (c) dbsp_ctrl_model_inst.cyc(1'b1, 1'b0, 8'h10, NOISE ^ PAIR_W'(r), 4'h0);
    endtask
    task automatic wr_rd(input logic [7:0] a, input logic [PAIR_W-1:0] d);
        dbsp_ctrl_model_inst.cyc(1'b0, 1'b0, a, NOISE, 4'h0);
        dbsp_ctrl_model_inst.cyc(1'b1, 1'b1, a, d, 4'h0);
        nop(2);
        r = dbsp_ctrl_model_inst.n;
        dbsp_ctrl_model_inst.cyc(1'b0, 1'b1, a, ~d, 4'h0);
        nop(4);
    endtask
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset();
        check(PAIR_W'({dq_oe, valid}), 36'h0);
        $display("test reset done");
    endtask
    // Full write, lane-masked rewrite, then a lone read
    task automatic t_masks();
        dbsp_ctrl_model_inst.cyc(1'b0, 1'b0, 8'h10, NOISE, 4'h0);
        dbsp_ctrl_model_inst.cyc(1'b1, 1'b1, 8'h10, 36'h2468ace01, 4'h0);
        wr_rd(8'h10, 36'h13579bdf3);
        check(rd(r, 2), 36'h13579bdf3);
        dbsp_ctrl_model_inst.cyc(1'b0, 1'b0, 8'h10, NOISE, 4'h0);
        dbsp_ctrl_model_inst.cyc(1'b1, 1'b1, 8'h10, 36'h2468ace01, 4'h6);
        wr_rd(8'h11, 36'h0f0f0f0f0);
        check(rd(r, 2), 36'h0f0f0f0f0);
        r = dbsp_ctrl_model_inst.n;
        dbsp_ctrl_model_inst.cyc(1'b0, 1'b1, 8'h10, NOISE, 4'h0);
        nop(4);
        check(rd(r, 2), 36'h24579bc01);
        check(PAIR_W'({dbsp_ctrl_model_inst.v_k[r+1],
                       dbsp_ctrl_model_inst.v_k[r+2]}), 36'h1);
        check(PAIR_W'({dbsp_ctrl_model_inst.oe_k[r+3],
                       dbsp_ctrl_model_inst.oe_k[r+4]}), 36'h2);
        $display("test masks done");
    endtask
    // Writes back to back, then reads back to back, the first at the just-written address
    task automatic t_stream();
        dbsp_ctrl_model_inst.cyc(1'b0, 1'b0, 8'h20, NOISE, 4'h0);
        dbsp_ctrl_model_inst.cyc(1'b0, 1'b0, 8'h21, 36'h0a5c3e7d1, 4'h0);
        r = dbsp_ctrl_model_inst.n;
        dbsp_ctrl_model_inst.cyc(1'b0, 1'b1, 8'h21, 36'h1b6d4f8e2, 4'h0);
        dbsp_ctrl_model_inst.cyc(1'b0, 1'b1, 8'h20, NOISE, 4'h0);
        nop(5);
        check(rd(r, 2), 36'h1b6d4f8e2);
        check(rd(r + 1, 2), 36'h0a5c3e7d1);
        check(PAIR_W'({dbsp_ctrl_model_inst.oe_k[r+4],
                       dbsp_ctrl_model_inst.oe_k[r+5]}), 36'h2);
        $display("test stream done");
    endtask
    // Lock after enough rises, recal count, then a stall drops the lock
    task automatic t_lock();
        while (dbsp_ctrl_model_inst.n < 2100) nop(1);
        check(PAIR_W'(locked), 36'h1);
        check(PAIR_W'(pulses), 36'h2);
        dbsp_ctrl_model_inst.hold(40, 1'b1);
        check(PAIR_W'(locked), 36'h0);
        $display("test lock done");
    endtask
    task automatic t_bypass();
        dbsp_ctrl_model_inst.hold(8, 1'b0);
        nop(2);
        wr_rd(8'h30, 36'h3c3c3c3c3);
        check(rd(r, 1), 36'h3c3c3c3c3);
        check(PAIR_W'(dbsp_ctrl_model_inst.v_k[r+1]), 36'h1);
        $display("test bypass done");
    endtask
    task automatic wrap_up();
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Run takes about 1.7 ms; the watchdog allows well over that
    initial begin
        #3000000;
        failures++;
        wrap_up();
    end
    initial begin
        resetn = 1'b0;
        r = 0;
        repeat (10) @(posedge core_clk);
        @(negedge core_clk);
        resetn = 1'b1;
        t_reset();
        t_masks();
        t_stream();
        t_lock();
        t_bypass();
        wrap_up();
    end
endmodule
